/* File: design/reload_timer_map.svh */
// Register offsets, field positions and reset values of the reload timer.
// Assumes inclusion by bare name from the timer module and the bench.
`ifndef RELOAD_TIMER_MAP_SVH
`define RELOAD_TIMER_MAP_SVH
`define MODE_ADDR 8'hA3
`define COUNT_ADDR 8'hA4
`define RELOAD_ADDR 8'hA5
`define FLAGS_ADDR 8'hA6
`define MODE_RUN_BIT 7
`define MODE_RATE_HI 6
`define MODE_RATE_LO 4
`define MODE_TRIG_BIT 0
`define FLAGS_IRQ_BIT 0
`define FLAGS_IEN_BIT 1
`define REG_RESET 8'h00
`define COUNT_FULL 8'hFF
`define COUNT_STEP 8'h01
`define PRESCALE_MAX 8'hFF
`define READ_ZERO 8'h00
`endif

/* File: design/reload_timer_pkg.sv */
// Types shared by the reload timer.
// Assumes the map header is on the include path.
package reload_timer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] rate_t;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_COUNT
   } run_state_t;
endpackage : reload_timer_pkg

/* File: design/pulse_triggered_reload_timer.sv */
// Eight-bit reload timer with prescaler, overflow flag and pulse trigger mode.
// Assumes a single 40 MHz clock; companion pulse status comes from another clock domain.
// What this block does
// - Counter holds while run enable is 0, counts when it is 1.
// - Counter adds one per tick; overflow is the tick taken at FF.
// - Overflow sets the request flag; software clears it.
// - An overflow with no count write in the same cycle reloads the counter from the active reload value.
// - Reload writes go to a holding buffer, moved to active on overflow.
// - With interrupt enable set, overflow raises an interrupt request.
// - Keeps counting in every power mode and never drives wake-up.
// - Rate codes 000 to 111 divide instruction clock by 256 down to 2.
// - Counter spans 256 steps, one per prescaled tick.
// - Trigger mode bit 0 is normal timing, 1 is pulse triggered.
// - In triggered mode, wait idle until a companion pulse starts.
// - A new trigger before overflow reloads and restarts without flag.
// - Overflow after pulse finished reloads, keeps counting, sets flag.
// - Overflow during active pulse reloads and flags, then clears companion bits one cycle later.
// - Companion trigger is software pulse bit when output on, source 0.
//
// Implementation choice: the plain strobed port.
`include "reload_timer_map.svh"
module pulse_triggered_reload_timer (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic instr_tick_in,
   input wire reload_timer_pkg::byte_t addr_in,
   input wire reload_timer_pkg::byte_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output reload_timer_pkg::byte_t rdata_out,
   input wire logic companion_pulse_output_enable_in,
   input wire logic companion_trigger_source_in,
   input wire logic companion_software_pulse_bit_in,
   input wire logic companion_pulse_active_in,
   output logic companion_shutdown_out,
   output logic irq_out,
   output logic wake_out
);
   import reload_timer_pkg::*;

   logic run_ff;
   rate_t rate_ff;
   logic trig_mode_ff;
   logic ien_ff;
   logic irq_ff;
   byte_t count_ff;
   byte_t reload_buf_ff;
   byte_t reload_act_ff;
   byte_t presc_ff;
   byte_t rdata_ff;
   run_state_t state_ff;
   logic [2:0] sw_sync_ff;
   logic [2:0] act_sync_ff;
   logic sw_level_ff;
   logic act_level_ff;
   logic trig_ff;
   logic shutdown_ff;

   // Rate code to tick mask: code 0 divides by 256, code 7 by 2
   function automatic byte_t rate_mask(input rate_t code);
      byte_t m;
      m = `PRESCALE_MAX >> code;
      return m;
   endfunction : rate_mask

   logic wr_mode;
   logic wr_count;
   logic wr_reload;
   logic wr_flags;
   logic tick;
   logic counting;
   logic overflow;
   logic trigger_ok;

   assign wr_mode = wr_in && (addr_in == `MODE_ADDR);
   assign wr_count = wr_in && (addr_in == `COUNT_ADDR);
   assign wr_reload = wr_in && (addr_in == `RELOAD_ADDR);
   assign wr_flags = wr_in && (addr_in == `FLAGS_ADDR);

   // Prescaler runs on instruction-clock strobes, reset while stopped
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in || !run_ff) begin
         presc_ff <= `REG_RESET;
      end else if (instr_tick_in) begin
         presc_ff <= presc_ff + `COUNT_STEP;
      end
   end
   assign tick = instr_tick_in && ((presc_ff & rate_mask(rate_ff)) == rate_mask(rate_ff));

   assign counting = (state_ff == ST_COUNT);
   assign overflow = counting && tick && (count_ff == `COUNT_FULL);

   // Companion status passes three flops; a change counts when stages two and three agree
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sw_sync_ff <= 3'h0;
         act_sync_ff <= 3'h0;
         sw_level_ff <= 1'b0;
         act_level_ff <= 1'b0;
      end else begin
         sw_sync_ff <= {sw_sync_ff[1:0], companion_software_pulse_bit_in};
         act_sync_ff <= {act_sync_ff[1:0], companion_pulse_active_in};
         if (sw_sync_ff[1] == sw_sync_ff[2]) begin
            sw_level_ff <= sw_sync_ff[2];
         end
         if (act_sync_ff[1] == act_sync_ff[2]) begin
            act_level_ff <= act_sync_ff[2];
         end
      end
   end

   // Source is the software pulse bit only when output on and source select 0
   assign trigger_ok = companion_pulse_output_enable_in && !companion_trigger_source_in;

   // Single-cycle trigger on rising software pulse bit
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         trig_ff <= 1'b0;
      end else begin
         trig_ff <= trigger_ok && sw_sync_ff[2] && !sw_level_ff && (sw_sync_ff[1] == sw_sync_ff[2]);
      end
   end

   // Mode register
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         run_ff <= 1'b0;
         rate_ff <= 3'h0;
         trig_mode_ff <= 1'b0;
      end else if (wr_mode) begin
         run_ff <= wdata_in[`MODE_RUN_BIT];
         rate_ff <= wdata_in[`MODE_RATE_HI:`MODE_RATE_LO];
         trig_mode_ff <= wdata_in[`MODE_TRIG_BIT];
      end
   end

   // Run state
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_ff <= ST_IDLE;
      end else if (!run_ff) begin
         state_ff <= ST_IDLE;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               state_ff <= trig_mode_ff ? ST_WAIT_TRIG : ST_COUNT;
            end
            ST_WAIT_TRIG: begin
               if (trig_ff) begin
                  state_ff <= ST_COUNT;
               end
            end
            ST_COUNT: begin
               state_ff <= ST_COUNT;
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Counter with auto reload
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         count_ff <= `REG_RESET;
      end else if (wr_count) begin
         count_ff <= wdata_in;
      end else if (overflow) begin
         count_ff <= reload_act_ff;
      end else if (counting && trig_mode_ff && trig_ff) begin
         count_ff <= reload_act_ff;
      end else if (counting && tick) begin
         count_ff <= count_ff + `COUNT_STEP;
      end
   end

   // Double-buffered reload: active copy follows the written copy at overflow
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         reload_buf_ff <= `REG_RESET;
         reload_act_ff <= `REG_RESET;
      end else begin
         if (wr_reload) begin
            reload_buf_ff <= wdata_in;
         end
         if (wr_reload && !run_ff) begin
            reload_act_ff <= wdata_in;
         end else if (overflow) begin
            reload_act_ff <= reload_buf_ff;
         end
      end
   end

   // Overflow flag and interrupt enable; set wins over clear
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_ff <= 1'b0;
         ien_ff <= 1'b0;
      end else begin
         if (wr_flags) begin
            ien_ff <= wdata_in[`FLAGS_IEN_BIT];
         end
         if (overflow) begin
            irq_ff <= 1'b1;
         end else if (wr_flags && !wdata_in[`FLAGS_IRQ_BIT]) begin
            irq_ff <= 1'b0;
         end
      end
   end
   assign irq_out = irq_ff && ien_ff;
   assign wake_out = 1'b0;

   // Forced companion shutdown on overflow during an active pulse
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         shutdown_ff <= 1'b0;
      end else begin
         shutdown_ff <= overflow && trig_mode_ff && act_level_ff;
      end
   end
   assign companion_shutdown_out = shutdown_ff;

   // Read data one cycle after the strobe; reload reads as zero
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rdata_ff <= `READ_ZERO;
      end else if (rd_in) begin
         unique case (addr_in)
            `MODE_ADDR: rdata_ff <= {run_ff, rate_ff, 3'h0, trig_mode_ff};
            `COUNT_ADDR: rdata_ff <= count_ff;
            `FLAGS_ADDR: rdata_ff <= {6'h00, ien_ff, irq_ff};
            default: rdata_ff <= `READ_ZERO;
         endcase
      end else begin
         rdata_ff <= `READ_ZERO;
      end
   end
   assign rdata_out = rdata_ff;

   chk_ovf_sets_flag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow |=> irq_ff) else $error("overflow did not set flag");
   chk_ovf_reloads: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow && !wr_count |=> count_ff == $past(reload_act_ff)) else $error("no reload at overflow");
   chk_buf_moves: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow && !wr_reload |=> reload_act_ff == $past(reload_buf_ff)) else $error("buffer not moved");
   chk_hold_stopped: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !run_ff && !wr_count && !$past(run_ff) |=> $stable(count_ff)) else $error("count moved while stopped");
   chk_irq_gate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow && ien_ff && !wr_flags |=> irq_out) else $error("enabled overflow gave no irq");
   chk_wait_trig: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      state_ff == ST_WAIT_TRIG && !wr_count |=> $stable(count_ff)) else $error("counted before trigger");
   chk_retrig_noflag: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      counting && trig_mode_ff && trig_ff && !overflow && !irq_ff && !wr_count |=> !irq_ff && count_ff == $past(reload_act_ff))
      else $error("retrigger misbehaved");
   chk_shutdown: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow && trig_mode_ff && act_level_ff |=> companion_shutdown_out ##1 (!companion_shutdown_out || $past(overflow)))
      else $error("no companion shutdown");
   chk_trig_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      trig_ff |=> !trig_ff) else $error("trigger longer than one cycle");

   // Counting, prescaler and run state
   chk_count_step: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      counting && tick && count_ff != `COUNT_FULL && !wr_count && !(trig_mode_ff && trig_ff)
      |=> count_ff == $past(count_ff) + `COUNT_STEP) else $error("count did not step");
   chk_step_per_tick: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      counting && !tick && !wr_count && !(trig_mode_ff && trig_ff) |=> $stable(count_ff))
      else $error("count moved without tick");
   chk_fast_rate: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      tick && (&rate_ff) |=> !tick) else $error("fastest rate ticked twice in a row");
   chk_presc_stopped: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !run_ff |=> presc_ff == `REG_RESET) else $error("prescaler ran while stopped");
   chk_idle_state: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !run_ff |=> state_ff == ST_IDLE) else $error("not idle while stopped");
   chk_normal_start: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      state_ff == ST_IDLE && run_ff && !trig_mode_ff |=> counting) else $error("normal mode did not start");
   chk_wait_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      state_ff == ST_WAIT_TRIG && run_ff && !trig_ff |=> state_ff == ST_WAIT_TRIG)
      else $error("left wait without trigger");

   // Flag, interrupt and reload buffer
   chk_flag_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      irq_ff && !wr_flags |=> irq_ff) else $error("flag dropped without software clear");
   chk_flag_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      wr_flags && !wdata_in[`FLAGS_IRQ_BIT] && !overflow |=> !irq_ff) else $error("flag clear ignored");
   chk_ien_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      wr_flags && !wdata_in[`FLAGS_IEN_BIT] |=> !irq_out) else $error("irq while disabled");
   chk_no_wake: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow |=> irq_ff && !wake_out) else $error("overflow drove wake-up");
   chk_buf_write: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      wr_reload |=> reload_buf_ff == $past(wdata_in)) else $error("reload write lost");
   chk_reload_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !overflow && !(wr_reload && !run_ff) |=> $stable(reload_act_ff)) else $error("active reload moved early");

   // Trigger mode and companion control
   chk_quiet_pulse: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      overflow && !act_level_ff |=> !companion_shutdown_out && irq_ff) else $error("finished pulse misbehaved");
   chk_shutdown_cause: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      companion_shutdown_out |-> $past(overflow) && $past(trig_mode_ff) && $past(act_level_ff))
      else $error("shutdown without cause");
   chk_trig_source: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      trig_ff |-> $past(trigger_ok)) else $error("trigger from wrong source");

   // Main scenarios
   cov_overflow: cover property (@(posedge mclk_in) disable iff (!rst_n_in) overflow);
   cov_retrigger: cover property (@(posedge mclk_in) disable iff (!rst_n_in) counting && trig_mode_ff && trig_ff);
   cov_shutdown: cover property (@(posedge mclk_in) disable iff (!rst_n_in) companion_shutdown_out);
   cov_wait_start: cover property (@(posedge mclk_in) disable iff (!rst_n_in) state_ff == ST_WAIT_TRIG && trig_ff);
   cov_fast_tick: cover property (@(posedge mclk_in) disable iff (!rst_n_in) tick && (&rate_ff));
endmodule : pulse_triggered_reload_timer

/* File: bench/companion_pulse_model.sv */
// Behavioural companion pulse generator feeding the timer's trigger inputs.
// Assumes the timer clock; the bench commands each pulse and its length.
module companion_pulse_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic fire_in,
   input wire logic [7:0] len_in,
   input wire logic shutdown_in,
   output logic out_en_out,
   output logic source_out,
   output logic sw_bit_out,
   output logic active_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_ff;
   assign source_out = 1'b0;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || shutdown_in) begin
         out_en_out <= 1'b0;
         sw_bit_out <= 1'b0;
         active_out <= 1'b0;
         left_ff <= 8'h00;
      end else if (fire_in) begin
         out_en_out <= 1'b1;
         sw_bit_out <= 1'b1;
         active_out <= 1'b1;
         left_ff <= len_in;
      end else if (left_ff != 8'h00) begin
         left_ff <= left_ff - 8'h01;
         sw_bit_out <= (left_ff != 8'h01);
         active_out <= (left_ff != 8'h01);
      end
   end
endmodule : companion_pulse_model

/* File: bench/tb_pulse_triggered_reload_timer.sv */
// Self-checking bench: register port, rates, double-buffered reload, trigger mode.
// Assumes the design package, map header and companion model are compiled first.
`include "reload_timer_map.svh"
module tb_pulse_triggered_reload_timer;
   timeunit 1ns;
   timeprecision 1ps;
   import reload_timer_pkg::*;
   typedef struct {rate_t rate; int div;} row_t;
   row_t rows[8] = '{'{3'h0, 256}, '{3'h1, 128}, '{3'h2, 64}, '{3'h3, 32}, '{3'h4, 16}, '{3'h5, 8},
      '{3'h6, 4}, '{3'h7, 2}};
   byte_t ra[5] = '{`MODE_ADDR, `COUNT_ADDR, `RELOAD_ADDR, `FLAGS_ADDR, 8'hB0};
   logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0, fire = 1'b0;
   byte_t addr = 8'h00, wdata = 8'h00, len = 8'h00, shut_cnt = 8'h00, rdata, rv;
   logic shut, irq, wake, pen, psrc, pbit, pact;
   int err_total = 0, check_count = 0, cyc = 0, t0, n;
   always #12.5 clk = ~clk;
   // Instruction strobe on every second clock
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tick <= ~tick;
      if (shut === 1'b1) shut_cnt <= shut_cnt + 8'h01;
   end
   pulse_triggered_reload_timer pulse_triggered_reload_timer_inst (.mclk_in(clk), .rst_n_in(rst_n),
      .instr_tick_in(tick), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .companion_pulse_output_enable_in(pen), .companion_trigger_source_in(psrc),
      .companion_software_pulse_bit_in(pbit), .companion_pulse_active_in(pact),
      .companion_shutdown_out(shut), .irq_out(irq), .wake_out(wake));
   companion_pulse_model companion_pulse_model_inst (.clk_in(clk), .rst_n_in(rst_n), .fire_in(fire),
      .len_in(len), .shutdown_in(shut), .out_en_out(pen), .source_out(psrc), .sw_bit_out(pbit),
      .active_out(pact));
   task automatic wr_reg(input byte_t a, input byte_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg
   task automatic rd_reg(input byte_t a, output byte_t d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   task automatic fire_pulse(input byte_t l);
      @(posedge clk);
      fire <= 1'b1;
      len <= l;
      @(posedge clk);
      fire <= 1'b0;
   endtask : fire_pulse
   // Polls the request flag and returns the cycles spent
   task automatic wait_flag();
      t0 = cyc;
      rv = 8'h00;
      for (int k = 0; k < 1200 && rv[0] !== 1'b1; k++)
         rd_reg(`FLAGS_ADDR, rv);
      n = cyc - t0;
   endtask : wait_flag
   task automatic chk_val(input byte_t got, input byte_t exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_span(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("unexpected span at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : chk_span
   task automatic setup(input byte_t v, input byte_t mode);
      wr_reg(`MODE_ADDR, 8'h00);
      wr_reg(`COUNT_ADDR, v);
      wr_reg(`RELOAD_ADDR, v);
      wr_reg(`FLAGS_ADDR, 8'h02);
      wr_reg(`MODE_ADDR, mode);
   endtask : setup
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ra[i]) begin
         rd_reg(ra[i], rv);
         chk_val(rv, `REG_RESET);
      end
      wr_reg(`MODE_ADDR, 8'h71);
      wr_reg(`COUNT_ADDR, 8'h55);
      repeat (40) @(posedge clk);
      rd_reg(`COUNT_ADDR, rv);
      chk_val(rv, 8'h55);
      rd_reg(`MODE_ADDR, rv);
      chk_val(rv, 8'h71);
      foreach (rows[i]) begin
         setup(`COUNT_FULL, {1'b1, rows[i].rate, 4'h0});
         wait_flag();
         chk_span(n, 2 * rows[i].div - 2, 2 * rows[i].div + 10);
         chk_val({7'h00, irq}, 8'h01);
         rd_reg(`COUNT_ADDR, rv);
         chk_val(rv, `COUNT_FULL);
      end
      wr_reg(`MODE_ADDR, 8'h00);
      wr_reg(`FLAGS_ADDR, 8'h01);
      chk_val({7'h00, irq}, 8'h00);
      rd_reg(`FLAGS_ADDR, rv);
      chk_val(rv, 8'h01);
      setup(8'hF0, 8'hF0);
      wr_reg(`RELOAD_ADDR, 8'h80);
      wait_flag();
      rd_reg(`COUNT_ADDR, rv);
      chk_span(rv, 'hF0, 'hF2);
      wr_reg(`FLAGS_ADDR, 8'h00);
      wait_flag();
      rd_reg(`COUNT_ADDR, rv);
      chk_span(rv, 'h80, 'h82);
      setup(8'hF0, 8'hF1);
      repeat (40) @(posedge clk);
      rd_reg(`COUNT_ADDR, rv);
      chk_val(rv, 8'hF0);
      fire_pulse(8'h04);
      repeat (30) @(posedge clk);
      fire_pulse(8'h04);
      repeat (10) @(posedge clk);
      rd_reg(`COUNT_ADDR, rv);
      chk_span(rv, 'hF0, 'hF2);
      rd_reg(`FLAGS_ADDR, rv);
      chk_val(rv, 8'h02);
      wait_flag();
      chk_val(rv, 8'h03);
      chk_val(shut_cnt, 8'h00);
      wr_reg(`FLAGS_ADDR, 8'h00);
      fire_pulse(8'hC8);
      wait_flag();
      chk_val(rv, 8'h01);
      chk_val(shut_cnt, 8'h01);
      chk_val({7'h00, pen}, 8'h00);
      chk_val({7'h00, wake}, 8'h00);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule : tb_pulse_triggered_reload_timer
